// *** core/ppcg_pkg.sv ***
/*
  Package for the port pin control and GPIO block: register offsets,
  field positions, reset values and encodings.
  Assumes a plain register port with 32-bit data and word addresses.
*/
package ppcg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OUT_DATA   = 8'h00; // Output data
  localparam logic [7:0] OFS_OUT_SET    = 8'h01; // Output set
  localparam logic [7:0] OFS_OUT_CLEAR  = 8'h02; // output_clear_reg
  localparam logic [7:0] OFS_OUT_TOGGLE = 8'h03; // Output toggle
  localparam logic [7:0] OFS_IN_DATA    = 8'h04; // Input data
  localparam logic [7:0] OFS_DIRECTION  = 8'h05; // pin_direction_reg
  localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h06; // Pin event flags
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h07; // Pin event enables
  localparam logic [7:0] OFS_PIN_CFG0   = 8'h10; // pin_config_reg, pin 0

  // ----------------------------------------------------------------
  // pin_config_reg field positions
  // ----------------------------------------------------------------
  localparam int PCR_PULL_SEL   = 0;  // Pull select: 1 up, 0 down
  localparam int PCR_PULL_EN    = 1;  // pull_enable
  localparam int PCR_SLEW       = 2;  // Slew: 1 slow, 0 fast
  localparam int PCR_FILTER     = 4;  // passive_filter_enable
  localparam int PCR_DRIVE      = 6;  // drive_strength_select
  localparam int PCR_FUNC_LO    = 8;  // Function select, 3 bits
  localparam int PCR_PIN_IRQ_CONFIG_LO    = 16; // pin_irq_config, 4 bits
  localparam int PCR_DMA_SEL    = 20; // 1 routes event to DMA
  localparam logic [31:0] PCR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] FUNC_ANALOG = 3'h0; // Analog or disabled
  localparam logic [2:0] FUNC_GPIO   = 3'h1; // GPIO
  localparam logic [3:0] PIN_IRQ_CONFIG_OFF     = 4'h0;
  localparam logic [3:0] PIN_IRQ_CONFIG_LOW     = 4'h8;
  localparam logic [3:0] PIN_IRQ_CONFIG_RISE    = 4'h9;
  localparam logic [3:0] PIN_IRQ_CONFIG_FALL    = 4'ha;
  localparam logic [3:0] PIN_IRQ_CONFIG_EITHER  = 4'hb;
  localparam logic [3:0] PIN_IRQ_CONFIG_HIGH    = 4'hc;

endpackage : ppcg_pkg

// *** core/ppcg_port.sv ***
/*
  Port pin control, pin event detection and GPIO for one port.
  Assumes inputs synchronous to CLK_SYS_IN and a zero-wait register
  port; pad wake-up path is combinational so it works without clock.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// Function
// - Each pin has own flag and enable
// - Per-pin rising, falling, either, low, high trigger
// - Per-pin choice of interrupt or DMA request
// - Event wake-up works without bus clock
// - Pin events work in every mux function
// - Per-pin pull up, down or none
// - Per-pin high or low drive strength
// - Per-pin fast or slow slew
// - Per-pin passive filter enable bit
// - Function select: analog, GPIO, six peripherals
// - Pad settings apply in every function
// - Input data reads pin in all modes
// - Set, clear, toggle registers modify output
// - Single-cycle zero-wait register access path
// - Config value 10 arms falling edge
// - Function value 1 selects GPIO
// - Direction bit one means output
// - Clear register write drives output low
module ppcg_port #(
  parameter int NPINS = 8 // Pins in the port
) (
  // Clock and reset
  input  wire logic             CLK_SYS_IN,
  input  wire logic             SYS_RST_IN,
  // Register port (single_cycle_io_path)
  input  wire logic [7:0]       REG_ADDR_IN,
  input  wire logic [31:0]      REG_WDATA_IN,
  input  wire logic             REG_WR_IN,
  input  wire logic             REG_RD_IN,
  output logic      [31:0]      REG_RDATA_OUT,
  // Pads
  input  wire logic [NPINS-1:0] PAD_IN,
  output logic      [NPINS-1:0] PAD_OUT,
  output logic      [NPINS-1:0] PAD_OE_N_OUT,
  output logic      [NPINS-1:0] PAD_PULL_EN_OUT,
  output logic      [NPINS-1:0] PAD_PULL_UP_OUT,
  output logic      [NPINS-1:0] PAD_DRIVE_HI_OUT,
  output logic      [NPINS-1:0] PAD_SLEW_SLOW_OUT,
  output logic      [NPINS-1:0] PAD_FILTER_EN_OUT,
  output logic      [NPINS*3-1:0] PAD_FUNC_OUT,
  // Peripheral functions
  input  wire logic [NPINS-1:0] PERIPH_OUT_IN,
  input  wire logic [NPINS-1:0] PERIPH_OE_IN,
  // Requests
  output logic                  IRQ_OUT,
  output logic      [NPINS-1:0] DMA_REQ_OUT,
  output logic                  WAKE_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NPINS-1:0] out_data_r;   // Output data
  logic [NPINS-1:0] out_data_nxt; // Next output data
  logic [NPINS-1:0] dir_r;        // Direction, 1 output
  logic [NPINS-1:0] in_data_r;    // Sampled pin level
  logic [NPINS-1:0] flag_r;       // Sticky event flags
  logic [NPINS-1:0] flag_nxt;     // Next flags
  logic [NPINS-1:0] irq_en_r;     // Per-pin enables
  logic [31:0]      pcr_r [NPINS]; // Pin config registers
  logic [31:0]      rdata_r;      // Read data register

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr_out   = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_OUT_DATA;
  wire logic wr_set   = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_OUT_SET;
  wire logic wr_clr   = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_OUT_CLEAR;
  wire logic wr_tog   = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_OUT_TOGGLE;
  wire logic wr_dir   = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_DIRECTION;
  wire logic wr_flag  = REG_WR_IN && REG_ADDR_IN == ppcg_pkg::OFS_IRQ_FLAGS;
  wire logic wr_irqen = REG_WR_IN
                        && REG_ADDR_IN == ppcg_pkg::OFS_IRQ_ENABLE;
  wire logic [NPINS-1:0] wmask = REG_WDATA_IN[NPINS-1:0];

  // ----------------------------------------------------------------
  // Output data next value
  // ----------------------------------------------------------------
  always_comb begin
    out_data_nxt = out_data_r;
    if (wr_out) begin
      out_data_nxt = wmask;
    end else if (wr_set) begin
      out_data_nxt = out_data_r | wmask;
    end else if (wr_clr) begin
      out_data_nxt = out_data_r & ~wmask;
    end else if (wr_tog) begin
      out_data_nxt = out_data_r ^ wmask;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin logic
  // ----------------------------------------------------------------
  logic [NPINS-1:0] event_hit;  // Detector fired this cycle
  logic [NPINS-1:0] dma_sel;    // Event routed to DMA
  logic [NPINS-1:0] prev_in;    // Previous sampled level
  logic [NPINS-1:0] async_hit;  // Unclocked detector for wake

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      wire logic [3:0] pin_irq_config = pcr_r[g][ppcg_pkg::PCR_PIN_IRQ_CONFIG_LO +: 4];
      wire logic [2:0] func = pcr_r[g][ppcg_pkg::PCR_FUNC_LO +: 3];
      wire logic       gpio = func == ppcg_pkg::FUNC_GPIO;
      wire logic       cur  = in_data_r[g];
      wire logic       rise = cur && !prev_in[g];
      wire logic       fall = !cur && prev_in[g];
      wire logic       wr_pcr = REG_WR_IN && REG_ADDR_IN ==
                        8'(ppcg_pkg::OFS_PIN_CFG0 + 8'(g));

      // Detector ignores function select
      assign event_hit[g] =
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_RISE   && rise) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_FALL   && fall) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_EITHER && (rise || fall)) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_LOW    && !cur) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_HIGH   && cur);
      // Raw pad comparison needs no clock for wake
      assign async_hit[g] =
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_RISE   && PAD_IN[g] && !cur) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_FALL   && !PAD_IN[g] && cur) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_EITHER && PAD_IN[g] != cur) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_LOW    && !PAD_IN[g]) ||
        (pin_irq_config == ppcg_pkg::PIN_IRQ_CONFIG_HIGH   && PAD_IN[g]);
      assign dma_sel[g] = pcr_r[g][ppcg_pkg::PCR_DMA_SEL];

      // Pad settings independent of function
      assign PAD_PULL_EN_OUT[g]   = pcr_r[g][ppcg_pkg::PCR_PULL_EN];
      assign PAD_PULL_UP_OUT[g]   = pcr_r[g][ppcg_pkg::PCR_PULL_SEL];
      assign PAD_DRIVE_HI_OUT[g]  = pcr_r[g][ppcg_pkg::PCR_DRIVE];
      assign PAD_SLEW_SLOW_OUT[g] = pcr_r[g][ppcg_pkg::PCR_SLEW];
      assign PAD_FILTER_EN_OUT[g] = pcr_r[g][ppcg_pkg::PCR_FILTER];
      assign PAD_FUNC_OUT[g*3 +: 3] = func;

      // Output mux: GPIO or peripheral; analog leaves pad undriven
      assign PAD_OUT[g] = gpio ? out_data_r[g] : PERIPH_OUT_IN[g];
      assign PAD_OE_N_OUT[g] = gpio ? !dir_r[g]
                             : (func == ppcg_pkg::FUNC_ANALOG)
                               || !PERIPH_OE_IN[g];

      // Pin config register
      always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
          pcr_r[g] <= ppcg_pkg::PCR_RESET;
        end else if (wr_pcr) begin
          pcr_r[g] <= REG_WDATA_IN;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_comb begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      flag_nxt = flag_r & ~wmask;
    end
    flag_nxt = flag_nxt | event_hit;
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      out_data_r <= '0;
      dir_r      <= '0;
      in_data_r  <= '0;
      prev_in    <= '0;
      flag_r     <= '0;
      irq_en_r   <= '0;
    end else begin
      out_data_r <= out_data_nxt;
      if (wr_dir) dir_r <= wmask;
      in_data_r  <= PAD_IN;
      prev_in    <= in_data_r;
      flag_r     <= flag_nxt;
      if (wr_irqen) irq_en_r <= wmask;
    end
  end

  // ----------------------------------------------------------------
  // Read mux, answer in the next cycle, no wait
  // ----------------------------------------------------------------
  logic [31:0] rd_mux; // Selected read value
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (REG_ADDR_IN)
      ppcg_pkg::OFS_OUT_DATA:   rd_mux[NPINS-1:0] = out_data_r;
      ppcg_pkg::OFS_IN_DATA:    rd_mux[NPINS-1:0] = in_data_r;
      ppcg_pkg::OFS_DIRECTION:  rd_mux[NPINS-1:0] = dir_r;
      ppcg_pkg::OFS_IRQ_FLAGS:  rd_mux[NPINS-1:0] = flag_r;
      ppcg_pkg::OFS_IRQ_ENABLE: rd_mux[NPINS-1:0] = irq_en_r;
      default: begin
        // Set, clear, toggle and unmapped read zero
        for (int i = 0; i < NPINS; i++) begin
          if (REG_ADDR_IN == 8'(ppcg_pkg::OFS_PIN_CFG0 + 8'(i)))
            rd_mux = pcr_r[i];
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) rdata_r <= 32'h0000_0000;
    else if (REG_RD_IN) rdata_r <= rd_mux;
    else rdata_r <= 32'h0000_0000;
  end
  assign REG_RDATA_OUT = rdata_r;

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  assign IRQ_OUT     = |(flag_r & irq_en_r & ~dma_sel);
  assign DMA_REQ_OUT = flag_r & irq_en_r & dma_sel;
  assign WAKE_OUT    = |((async_hit | flag_r) & irq_en_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  AST_CLR_LOW: assert property (wr_clr |=> (out_data_r & $past(wmask)) == '0)
    else $error("Clear write left an output bit high");
  AST_SET_HIGH: assert property (wr_set |=> (out_data_r & $past(wmask)) == $past(wmask))
    else $error("Set write left an output bit low");
  AST_TOG_FLIP: assert property (wr_tog |=> out_data_r == ($past(out_data_r) ^ $past(wmask)))
    else $error("Toggle write gave wrong output");
  AST_IN_FOLLOW: assert property (##1 in_data_r == $past(PAD_IN))
    else $error("Input data not the sampled pad");
  AST_FLAG_STICKY: assert property ((flag_r != '0) && !wr_flag |=> (flag_r & $past(flag_r)) == $past(flag_r))
    else $error("Flag dropped without a clear");
  AST_FALL_SET: assert property ((pcr_r[0][19:16] == ppcg_pkg::PIN_IRQ_CONFIG_FALL) && prev_in[0] && !in_data_r[0] |=> flag_r[0])
    else $error("Falling edge did not set the flag");
  AST_DIR_OE: assert property ((pcr_r[0][10:8] == ppcg_pkg::FUNC_GPIO) |-> PAD_OE_N_OUT[0] == !dir_r[0])
    else $error("GPIO enable does not follow direction");
  AST_RD_ZERO: assert property (REG_RD_IN && REG_ADDR_IN == ppcg_pkg::OFS_OUT_SET |=> REG_RDATA_OUT == 32'h0000_0000)
    else $error("Set register read not zero");
  AST_IRQ_OR: assert property (IRQ_OUT == |(flag_r & irq_en_r & ~dma_sel))
    else $error("Interrupt not OR of enabled flags");

  COV_FALL: cover property (prev_in[0] && !in_data_r[0] ##1 flag_r[0]);
  COV_DMA: cover property (DMA_REQ_OUT != '0);
  COV_CLEAR: cover property (wr_flag && flag_r != '0);

endmodule : ppcg_port

// *** tb/ppcg_pad_model.sv ***
/*
  Pad and board model for the port block: resolves each pin level from
  the port's own drive, an outside driver and the pad pull.
  Assumes the bench steers the outside driver per pin.
*/
`timescale 1ns/100ps
module ppcg_pad_model #(
  parameter int NP = 8 // Pins modelled
) (
  // Clock
  input  wire logic          clk_in,
  // Port side of the pads
  input  wire logic [NP-1:0] pad_out_in,
  input  wire logic [NP-1:0] oe_n_in,
  input  wire logic [NP-1:0] pull_en_in,
  input  wire logic [NP-1:0] pull_up_in,
  // Outside driver
  input  wire logic [NP-1:0] ext_en_in,
  input  wire logic [NP-1:0] ext_lvl_in,
  // Level seen at the pins
  output logic      [NP-1:0] pad_in_out
);
  logic [NP-1:0] churn_r = '0; // Floating pins wander every cycle

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Undriven unpulled pin never holds a stale value
  always_ff @(posedge clk_in) churn_r <= ~churn_r;

  // Port drive first, then outside driver, then pull
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (!oe_n_in[i]) pad_in_out[i] = pad_out_in[i];
      else if (ext_en_in[i]) pad_in_out[i] = ext_lvl_in[i];
      else if (pull_en_in[i]) pad_in_out[i] = pull_up_in[i];
      else pad_in_out[i] = churn_r[i];
    end
  end
endmodule : ppcg_pad_model

// *** tb/ppcg_port_test.sv ***
/*
  Self-checking bench for the port block: register path, GPIO output
  modify registers, pad settings, input data and pin events.
  Assumes the pad model file is compiled before this one.
*/
`timescale 1ns/100ps
module ppcg_port_test;
  logic        clk, rst, wr, rd, rd_d, irq, wake;
  logic [7:0]  addr, pad_in, pad_out, oe_n, pen, pup, drv, slw, flt, dma;
  logic [7:0]  ext_en, ext_lvl, p_out, p_oe;
  logic [23:0] func;
  logic [31:0] wd, rdata, seed, c, e1, e2;
  logic [31:0] expq[$];   // Expected read data, oldest first
  logic [3:0]  md[5];     // Event modes under test
  logic [4:0]  pre;       // Idle level per mode
  logic [2:0]  f;
  int          n_fail, n_compared, cycles, i;

  ppcg_port i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N_OUT(oe_n),
    .PAD_PULL_EN_OUT(pen), .PAD_PULL_UP_OUT(pup), .PAD_DRIVE_HI_OUT(drv),
    .PAD_SLEW_SLOW_OUT(slw), .PAD_FILTER_EN_OUT(flt), .PAD_FUNC_OUT(func),
    .PERIPH_OUT_IN(p_out), .PERIPH_OE_IN(p_oe), .IRQ_OUT(irq),
    .DMA_REQ_OUT(dma), .WAKE_OUT(wake));
  ppcg_pad_model i_pads (.clk_in(clk), .pad_out_in(pad_out),
    .oe_n_in(oe_n), .pull_en_in(pen), .pull_up_in(pup), .ext_en_in(ext_en),
    .ext_lvl_in(ext_lvl), .pad_in_out(pad_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wr   <= 1'b0;
  endtask : wrr
  task automatic rdd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rdd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic results;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Clock, read-data watcher and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rd_d && expq.size() > 0) chk(rdata, expq.pop_front());
    rd_d <= rd;
    if (cycles > 4000) begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {wr, rd, rd_d, addr, wd, p_out, p_oe, ext_lvl} = '0;
    {n_fail, n_compared, cycles} = '0;
    ext_en = 8'hff;
    seed = 32'hbe7c_abe3;
    md = '{ppcg_pkg::PIN_IRQ_CONFIG_LOW, ppcg_pkg::PIN_IRQ_CONFIG_RISE, ppcg_pkg::PIN_IRQ_CONFIG_FALL,
           ppcg_pkg::PIN_IRQ_CONFIG_EITHER, ppcg_pkg::PIN_IRQ_CONFIG_HIGH};
    pre = 5'b0_1101;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset state, unmapped address
    rdd(ppcg_pkg::OFS_DIRECTION, 32'h0000_0000);
    rdd(ppcg_pkg::OFS_PIN_CFG0, 32'h0000_0000);
    rdd(8'h08, 32'h0000_0000);
    // GPIO outputs and modify registers
    for (i = 0; i < 8; i++) wrr(ppcg_pkg::OFS_PIN_CFG0 + 8'(i), 32'h0000_0100);
    ext_en <= 8'h00;
    wrr(ppcg_pkg::OFS_DIRECTION, 32'h0000_00ff);
    wrr(ppcg_pkg::OFS_OUT_DATA, 32'h0000_00a5);
    wrr(ppcg_pkg::OFS_OUT_SET, 32'h0000_000f);
    rdd(ppcg_pkg::OFS_OUT_DATA, 32'h0000_00af);
    wrr(ppcg_pkg::OFS_OUT_CLEAR, 32'h0000_0003);
    rdd(ppcg_pkg::OFS_OUT_DATA, 32'h0000_00ac);
    wrr(ppcg_pkg::OFS_OUT_TOGGLE, 32'h0000_00ff);
    rdd(ppcg_pkg::OFS_OUT_SET, 32'h0000_0000);
    rdd(ppcg_pkg::OFS_OUT_CLEAR, 32'h0000_0000);
    rdd(ppcg_pkg::OFS_OUT_TOGGLE, 32'h0000_0000);
    rdd(ppcg_pkg::OFS_IN_DATA, 32'h0000_0053);
    #1 chk({oe_n, pad_out}, 32'h0000_0053);
    // Inputs driven from outside
    wrr(ppcg_pkg::OFS_DIRECTION, 32'h0000_0000);
    seed = lfsr(seed);
    ext_en  <= 8'hff;
    ext_lvl <= seed[7:0];
    cyc(3);
    rdd(ppcg_pkg::OFS_IN_DATA, {24'h0, seed[7:0]});
    #1 chk(oe_n, 32'h0000_00ff);
    // Peripheral functions with random pad settings
    {e1, e2} = '0;
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      f = 3'(8'd2 + seed[15:8] % 8'd6);
      c = {21'h0, f, 1'b0, seed[6], 1'b0, seed[4], 1'b0, seed[2:0]};
      {e1[24+i], e1[16+i], e1[8+i], e1[i]} = {c[1], c[0], c[2], c[4]};
      e2[24+i] = c[6];
      e2[3*i+:3] = f;
      wrr(ppcg_pkg::OFS_PIN_CFG0 + 8'(i), c);
      rdd(ppcg_pkg::OFS_PIN_CFG0 + 8'(i), c);
    end
    seed = lfsr(seed);
    p_out   <= seed[7:0];
    p_oe    <= 8'h0e;
    ext_en  <= 8'hf1;
    ext_lvl <= seed[15:8];
    cyc(3);
    rdd(ppcg_pkg::OFS_IN_DATA, {24'h0, seed[15:12], seed[3:1], seed[8]});
    #1 chk({pen, pup, slw, flt}, e1);
    chk({drv, func}, e2);
    chk({oe_n, pad_out}, {16'h0, 8'hf1, seed[7:0]});
    // Pin events in every mode, pin 0 left on a peripheral function
    wrr(ppcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      wrr(ppcg_pkg::OFS_PIN_CFG0, {12'h0, md[i], 16'h0300});
      ext_lvl[0] <= pre[i];
      cyc(4);
      wrr(ppcg_pkg::OFS_IRQ_FLAGS, 32'h0000_00ff);
      cyc(2);
      rdd(ppcg_pkg::OFS_IRQ_FLAGS, 32'h0000_0000);
      ext_lvl[0] <= ~pre[i];
      cyc(4);
      rdd(ppcg_pkg::OFS_IRQ_FLAGS, 32'h0000_0001);
      #1 chk({wake, irq, dma[0]}, 32'h0000_0006);
    end
    // Enable gates the request, flag stays
    wrr(ppcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    #1 chk(irq, 32'h0000_0000);
    rdd(ppcg_pkg::OFS_IRQ_FLAGS, 32'h0000_0001);
    // Falling edge routed to DMA
    wrr(ppcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    wrr(ppcg_pkg::OFS_PIN_CFG0, {11'h0, 1'b1, ppcg_pkg::PIN_IRQ_CONFIG_FALL, 16'h0300});
    wrr(ppcg_pkg::OFS_IRQ_FLAGS, 32'h0000_00ff);
    ext_lvl[0] <= 1'b0;
    cyc(4);
    #1 chk({irq, dma[0]}, 32'h0000_0001);
    cyc(2);
    results();
  end
endmodule : ppcg_port_test
